// file: design/flash_sp_pkg.sv
// state types for the status/protect block
package flash_sp_pkg;

  // what the link side does with the bytes of a frame
  typedef enum logic [2:0] {md_cmd, md_wsr, md_id, md_stat, md_dead} mode_e;

  // link clock domain state
  typedef struct packed {
    logic [2:0] cnt;
    logic [1:0] nbytes;
    logic [7:0] shift;
    logic [7:0] opcode;
    logic [7:0] data;
    logic [7:0] tx;
    mode_e mode;
    logic [7:0] st_meta;
    logic [7:0] st_sync;
  } link_s;

  // system clock domain state
  typedef struct packed {
    logic cs_meta;
    logic cs_sync;
    logic cs_prev;
    logic wp_meta;
    logic wp_sync;
    logic write_latch_bit;
    logic wr_busy;
    logic status_lock_bit;
    logic [2:0] protect_level;
    logic err;
    logic [17:0] timer;
    logic go;
    logic hwl;
    logic [7:0] stat;
  } sys_s;

endpackage

// file: design/flash_sp_regs.svh
// opcodes, status bit positions, reset values and timing for the status/protect block
`ifndef FLASH_SP_REGS_SVH
`define FLASH_SP_REGS_SVH

// command opcodes
`define OP_WL_SET 8'h06
`define OP_WL_CLR 8'h04
`define OP_READ_ID 8'h9F
`define OP_STAT_RD 8'h05
`define OP_STAT_WR 8'h01

// status byte bit positions
`define ST_BUSY 0
`define ST_LATCH 1
`define ST_LVL_LO 2
`define ST_LVL_HI 4
`define ST_ZERO 5
`define ST_ERR 6
`define ST_LOCK 7

// reset values
`define LOCK_RESET 1'b0
`define LEVEL_RESET 3'h0
`define STAT_RESET 8'h00
`define TIMER_RESET 18'h00000

// array command kinds and protection
`define KIND_PROG 2'h0
`define KIND_SECT 2'h1
`define KIND_CHIP 2'h2
`define LEVEL_ALL 3'h6
`define SECTOR_COUNT 6'h20

// status write time and its length in sys_clk cycles
`define STATUS_WRITE_TIME_US 10000
`define SYS_CLK_NS 50
`define STATUS_WRITE_CYCLES (`STATUS_WRITE_TIME_US * 1000 / `SYS_CLK_NS)

`endif

// file: design/flash_status_protect.sv
// serial flash command handling for write latch, ident read, status read/write, protection
// Operation
// R1 - write-latch-set command sets the write latch bit
// R2 - host sends write-latch-set before each program, erase or status write
// R3 - write-latch-set frame is exactly one opcode byte
// R4 - write-latch-clear command, one byte, clears the write latch bit
// R5 - latch clears at reset, latch-clear, status write, program or erase completion
// R6 - ident read shifts out manufacturer, memory type, device code bytes
// R7 - chip select high ends ident output at any point; output released
// R8 - ident opcode ignored while a program or erase runs
// R9 - chip select high after ident returns the device to standby
// R10 - status read accepted anytime, repeats status bytes while selected
// R11 - host should poll busy before new commands during a cycle
// R12 - status byte: lock, error, zero, level hi..lo, latch, busy
// R13 - busy reads one while program, erase or status write runs
// R14 - program, erase, status write refused while latch is zero
// R15 - protect level blocks region; chip erase only with level zero
// R16 - error flag set on failed operation; retries still accepted
// R17 - status write frame is opcode plus one data byte
// R18 - status write rejected unless chip select rises on byte boundary
// R19 - status write changes only lock and level bits
// R20 - status write cycle starts at chip select rise, busy then latch clears
// R21 - lock zero, or lock one with pin high, allows status write
// R22 - lock one with pin low rejects status writes until pin goes high
// R23 - opcodes 06 latch set, 04 latch clear, 9F ident read
// R24 - opcodes 05 status read, 01 status write
// R25 - latch set/clear rejected unless chip select rises on byte boundary
// R26 - input sampled on rising clock, output changes on falling clock
// R27 - each status byte shows current busy and latch values
`timescale 1ns/10ps
`include "flash_sp_regs.svh"

module flash_status_protect #(
  parameter int STATUS_WRITE_CYCLES = `STATUS_WRITE_CYCLES,
  parameter logic [7:0] MFR_CODE = 8'hA5, // arbitrary value
  parameter logic [7:0] TYPE_CODE = 8'h3C, // arbitrary value
  parameter logic [7:0] DEV_CODE = 8'h5A // arbitrary value
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  input wire logic wp_n,
  input wire logic array_req,
  input wire logic [1:0] array_kind,
  input wire logic [4:0] array_sector,
  input wire logic array_busy,
  input wire logic array_done,
  input wire logic array_fail,
  output logic array_go,
  output logic write_latch_bit,
  output logic busy_flag,
  output logic hardware_lock_mode,
  output logic [7:0] status_byte
);

  flash_sp_pkg::link_s lq;
  flash_sp_pkg::link_s ln;
  flash_sp_pkg::sys_s q;
  flash_sp_pkg::sys_s n;
  logic fresh;
  logic [2:0] cnt_now;
  logic [1:0] nb_now;
  flash_sp_pkg::mode_e mode_now;
  logic [7:0] sh;
  logic rise;
  logic bound;
  logic busy;
  logic hw;
  logic ev_set;
  logic ev_clr;
  logic ev_wsr;
  logic wsr_try;
  logic prot;
  logic [5:0] prot_lim;

  // frame start marker, held set while deselected
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  // link side: shift in on rising edge and decode each byte
  always_comb begin
    ln = lq;
    ln.st_meta = q.stat;
    ln.st_sync = lq.st_meta;
    cnt_now = fresh ? 3'h0 : lq.cnt;
    nb_now = fresh ? 2'h0 : lq.nbytes;
    mode_now = fresh ? flash_sp_pkg::md_cmd : lq.mode;
    sh = {lq.shift[6:0], si}; // [R26]
    ln.shift = sh;
    ln.cnt = cnt_now + 3'h1;
    ln.nbytes = nb_now;
    ln.mode = mode_now;
    if (cnt_now == 3'h7) begin
      if (nb_now != 2'h3) begin
        ln.nbytes = nb_now + 2'h1;
      end
      case (mode_now)
        flash_sp_pkg::md_cmd: begin
          ln.opcode = sh;
          ln.mode = flash_sp_pkg::md_dead;
          if (sh == `OP_READ_ID) begin // [R23]
            if (!lq.st_sync[`ST_BUSY]) begin // [R8]
              ln.mode = flash_sp_pkg::md_id;
              ln.tx = MFR_CODE; // [R6]
            end
          end else if (sh == `OP_STAT_RD) begin // [R24]
            ln.mode = flash_sp_pkg::md_stat;
            ln.tx = lq.st_sync; // [R10]
          end else if (sh == `OP_STAT_WR) begin
            ln.mode = flash_sp_pkg::md_wsr;
          end
        end
        flash_sp_pkg::md_wsr: begin
          ln.data = sh; // [R17]
          ln.mode = flash_sp_pkg::md_dead;
        end
        flash_sp_pkg::md_id: begin
          if (nb_now == 2'h1) begin
            ln.tx = TYPE_CODE; // [R6]
          end else if (nb_now == 2'h2) begin
            ln.tx = DEV_CODE;
          end else begin
            ln.mode = flash_sp_pkg::md_dead;
          end
        end
        flash_sp_pkg::md_stat: begin
          ln.tx = lq.st_sync; // [R27]
        end
        default: begin
        end
      endcase
    end
  end

  // link side registers; held while the link clock stands still
  always_ff @(posedge sclk) begin
    lq <= ln;
  end

  // serial output changes on falling edge, released at once on deselect
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      so <= 1'b0; // [R7] [R9]
      so_oe <= 1'b0;
    end else begin
      so <= lq.tx[~lq.cnt]; // [R26]
      so_oe <= !fresh && (lq.mode == flash_sp_pkg::md_id || lq.mode == flash_sp_pkg::md_stat);
    end
  end

  // system side: command completion at deselect, protection, timers
  always_comb begin
    n = q;
    n.cs_meta = cs_n;
    n.cs_sync = q.cs_meta;
    n.cs_prev = q.cs_sync;
    n.wp_meta = wp_n;
    n.wp_sync = q.wp_meta;
    n.go = 1'b0;
    // link fields are stable here: the link clock stops while deselected
    rise = q.cs_sync && !q.cs_prev;
    bound = (lq.cnt == 3'h0); // [R18] [R25]
    busy = q.wr_busy || array_busy;
    hw = q.status_lock_bit && !q.wp_sync; // [R22]
    ev_set = rise && bound && lq.nbytes == 2'h1 && lq.opcode == `OP_WL_SET;
    ev_clr = rise && bound && lq.nbytes == 2'h1 && lq.opcode == `OP_WL_CLR;
    wsr_try = rise && bound && lq.nbytes == 2'h2 && lq.opcode == `OP_STAT_WR;
    ev_wsr = wsr_try && q.write_latch_bit && !busy && !hw; // [R14] [R21] [R22]
    prot_lim = `SECTOR_COUNT - (6'h01 << (q.protect_level - 3'h1));
    if (array_kind == `KIND_CHIP) begin
      prot = (q.protect_level != 3'h0); // [R15]
    end else if (q.protect_level == 3'h0) begin
      prot = 1'b0;
    end else if (q.protect_level >= `LEVEL_ALL) begin
      prot = 1'b1;
    end else begin
      prot = ({1'b0, array_sector} >= prot_lim); // [R15]
    end
    // self-timed status write cycle
    if (q.wr_busy) begin
      if (q.timer == `TIMER_RESET) begin
        n.wr_busy = 1'b0; // [R20]
        n.write_latch_bit = 1'b0; // [R5]
      end else begin
        n.timer = q.timer - 18'h00001;
      end
    end
    if (ev_wsr) begin
      n.status_lock_bit = lq.data[`ST_LOCK]; // [R19]
      n.protect_level = lq.data[`ST_LVL_HI:`ST_LVL_LO];
      n.wr_busy = 1'b1; // [R20]
      n.timer = 18'(STATUS_WRITE_CYCLES - 1);
    end
    // array operations join through request, busy and done
    if (array_req && q.write_latch_bit && !busy && !prot) begin // [R14] [R16]
      n.go = 1'b1;
      n.err = 1'b0;
    end
    if (array_done) begin
      n.write_latch_bit = 1'b0; // [R5]
      if (array_fail) begin
        n.err = 1'b1; // [R16]
      end
    end
    if (ev_clr) begin
      n.write_latch_bit = 1'b0; // [R4]
    end
    if (ev_set) begin
      n.write_latch_bit = 1'b1; // [R1]
    end
    // hardware lock read from the second synchroniser flop only
    n.hwl = n.status_lock_bit && !q.wp_sync; // [R22]
    // status byte as seen by status read
    n.stat[`ST_LOCK] = n.status_lock_bit; // [R12]
    n.stat[`ST_ERR] = n.err;
    n.stat[`ST_ZERO] = 1'b0;
    n.stat[`ST_LVL_HI:`ST_LVL_LO] = n.protect_level;
    n.stat[`ST_LATCH] = n.write_latch_bit;
    n.stat[`ST_BUSY] = n.wr_busy || array_busy; // [R13]
  end

  // system side registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      q.cs_meta <= 1'b1;
      q.cs_sync <= 1'b1;
      q.cs_prev <= 1'b1;
      q.wp_meta <= 1'b1;
      q.wp_sync <= 1'b1;
      q.write_latch_bit <= 1'b0; // [R5]
      q.wr_busy <= 1'b0;
      q.status_lock_bit <= `LOCK_RESET;
      q.protect_level <= `LEVEL_RESET;
      q.err <= 1'b0;
      q.timer <= `TIMER_RESET;
      q.go <= 1'b0;
      q.hwl <= 1'b0;
      q.stat <= `STAT_RESET;
    end else begin
      q <= n;
    end
  end

  // outputs straight from flops
  assign array_go = q.go;
  assign write_latch_bit = q.write_latch_bit;
  assign busy_flag = q.stat[`ST_BUSY];
  assign hardware_lock_mode = q.hwl;
  assign status_byte = q.stat;

  // checks on the system side
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  latch_set_a: assert property (ev_set |=> write_latch_bit) // [R1]
    else $error("latch not set");
  latch_clear_a: assert property (ev_clr && !ev_set |=> !write_latch_bit) // [R4]
    else $error("latch not cleared");
  wsr_start_a: assert property (ev_wsr |=> q.wr_busy ##0 busy_flag[*2]) // [R20]
    else $error("status write did not start busy");
  wsr_end_a: assert property (q.wr_busy && q.timer == 18'h0 && !ev_set
    |=> !q.wr_busy && !write_latch_bit) // [R20]
    else $error("status write end wrong");
  hw_lock_a: assert property (wsr_try && q.status_lock_bit && !q.wp_sync
    |=> $stable(q.protect_level) && $stable(q.status_lock_bit) && !q.wr_busy) // [R22]
    else $error("status written in hardware lock");
  no_latch_a: assert property (wsr_try && !q.write_latch_bit |=> !q.wr_busy) // [R14]
    else $error("status write without latch");
  go_latch_a: assert property (array_go |-> $past(q.write_latch_bit) && !$past(busy)) // [R14]
    else $error("array start without latch");
  chip_lvl_a: assert property (array_go && $past(array_kind) == `KIND_CHIP
    |-> $past(q.protect_level) == 3'h0) // [R15]
    else $error("chip erase under protection");
  err_set_a: assert property (array_done && array_fail |=> status_byte[`ST_ERR]) // [R16]
    else $error("error flag not set");
  stat_bits_a: assert property (status_byte[`ST_ZERO] == 1'b0
    && status_byte[`ST_LATCH] == $past(n.write_latch_bit)) // [R12]
    else $error("status layout wrong");

  latch_set_c: cover property (ev_set);
  wsr_run_c: cover property (ev_wsr ##[1:30] !q.wr_busy);
  hw_reject_c: cover property (wsr_try && hw && q.write_latch_bit);
  array_go_c: cover property (array_go);

endmodule // flash_status_protect

// file: sim/spi_host_model.sv
// spi host model driving chip select, serial clock and serial input
`timescale 1ns/10ps
module spi_host_model (
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so
);
  // clock stands still low between frames
  // a clean deselect edge at start so the link side leaves its unknown state
  initial begin
    sclk = 1'b0;
    cs_n = 1'b0;
    si = 1'b0;
    #5 cs_n = 1'b1;
  end
  // one frame: bits leave msb first, so is taken at each rising clock
  task automatic xfer(input int nbits, input logic [31:0] tx, output logic [31:0] rx);
    rx = 32'h00000000;
    cs_n = 1'b0;
    #20;
    for (int i = 0; i < nbits; i++) begin
      si = tx[31 - (i % 32)];
      #15 sclk = 1'b1;
      rx = {rx[30:0], so};
      #15 sclk = 1'b0;
    end
    #10 cs_n = 1'b1;
    si = ~si; // released line shows no stale value
    #300;
  endtask
endmodule // spi_host_model

// file: sim/tb_top.sv
// self-checking bench for the status and protection block
`timescale 1ns/10ps
`include "flash_sp_regs.svh"
module tb_top;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic wp_n = 1'b1;
  logic array_req = 1'b0;
  logic [1:0] array_kind = 2'h0;
  logic [4:0] array_sector = 5'h00;
  logic array_busy = 1'b0;
  logic array_done = 1'b0;
  logic array_fail = 1'b0;
  logic sclk, cs_n, si, so, so_oe, array_go, write_latch_bit, busy_flag, hardware_lock_mode;
  logic [7:0] status_byte, obs_v, d;
  logic [31:0] rx;
  logic [7:0] exp_q[$];
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  event got;
  // serial output line as the host sees it: pulled up while released
  wire logic so_line;
  assign so_line = so_oe ? so : 1'b1;
  // system clock
  always #25 sys_clk = ~sys_clk;
  spi_host_model host_u (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so_line));
  flash_status_protect #(.STATUS_WRITE_CYCLES(20)) dut_u (.sys_clk(sys_clk), .srst(srst),
    .sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe), .wp_n(wp_n),
    .array_req(array_req), .array_kind(array_kind), .array_sector(array_sector),
    .array_busy(array_busy), .array_done(array_done), .array_fail(array_fail),
    .array_go(array_go), .write_latch_bit(write_latch_bit), .busy_flag(busy_flag),
    .hardware_lock_mode(hardware_lock_mode), .status_byte(status_byte));
  task automatic finish_test;
    $display("TB: %0d checks, %0d mismatches", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_tests++;
    if (seen !== want) begin
      n_fail++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  // note the expected value, then hand the observation to the watcher
  task automatic expect_val(input logic [7:0] want, input logic [7:0] seen);
    exp_q.push_back(want);
    obs_v = seen;
    -> got;
    #1;
  endtask
  // watcher pairs each observation with the oldest note
  always @(got) check(obs_v, exp_q.pop_front());
  // hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic rd_status(input logic [7:0] want);
    host_u.xfer(16, 32'h05000000, rx);
    expect_val(want, rx[7:0]);
  endtask
  task automatic wsr(input logic [7:0] v);
    while (busy_flag !== 1'b0) @(posedge sys_clk);
    host_u.xfer(8, 32'h06000000, rx);
    host_u.xfer(16, {8'h01, v, 16'h0000}, rx);
  endtask
  task automatic req(input logic [1:0] k, input logic [4:0] s, input logic want);
    @(posedge sys_clk);
    array_req <= 1'b1;
    array_kind <= k;
    array_sector <= s;
    @(posedge sys_clk);
    array_req <= 1'b0;
    #1; // grant stands only for the cycle after the request edge
    expect_val({7'h00, want}, {7'h00, array_go});
  endtask
  // main sequence
  initial begin
    void'($urandom(32'h1499));
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    idle(5);
    rd_status(8'h00);
    host_u.xfer(8, 32'h06000000, rx);
    rd_status(8'h02);
    host_u.xfer(8, 32'h04000000, rx);
    rd_status(8'h00);
    host_u.xfer(9, 32'h06000000, rx);
    rd_status(8'h00);
    $display("TB: latch tests done");
    host_u.xfer(32, 32'h9F000000, rx);
    expect_val(8'hA5, rx[23:16]);
    expect_val(8'h3C, rx[15:8]);
    expect_val(8'h5A, rx[7:0]);
    host_u.xfer(12, 32'h9F000000, rx);
    expect_val(8'h0A, {4'h0, rx[3:0]});
    expect_val(8'h00, {7'h00, so_oe});
    $display("TB: ident tests done");
    d = 8'($urandom) & 8'h7F;
    wsr(d);
    idle(6);
    expect_val(8'h01, {7'h00, busy_flag});
    host_u.xfer(40, 32'h05000000, rx);
    expect_val({3'b000, d[4:2], 2'b11}, rx[31:24]);
    expect_val({3'b000, d[4:2], 2'b00}, rx[7:0]);
    host_u.xfer(16, 32'h01800000, rx);
    idle(30);
    rd_status({3'b000, d[4:2], 2'b00});
    host_u.xfer(8, 32'h06000000, rx);
    host_u.xfer(15, 32'h01800000, rx);
    idle(30);
    rd_status({3'b000, d[4:2], 2'b10});
    wsr(8'h80);
    idle(30);
    rd_status(8'h80);
    @(posedge sys_clk) wp_n <= 1'b0;
    idle(5);
    expect_val(8'h01, {7'h00, hardware_lock_mode});
    wsr(8'h00);
    idle(30);
    rd_status(8'h82);
    @(posedge sys_clk) wp_n <= 1'b1;
    idle(5);
    wsr(8'h04);
    idle(30);
    rd_status(8'h04);
    $display("TB: status write tests done");
    req(`KIND_PROG, 5'h00, 1'b0);
    host_u.xfer(8, 32'h06000000, rx);
    req(`KIND_PROG, 5'h1F, 1'b0);
    req(`KIND_CHIP, 5'h00, 1'b0);
    req(`KIND_SECT, 5'($urandom_range(0, 30)), 1'b1);
    @(posedge sys_clk) array_busy <= 1'b1;
    idle(3);
    expect_val(8'h01, {7'h00, busy_flag});
    host_u.xfer(32, 32'h9F000000, rx);
    expect_val(8'hFF, rx[23:16] & rx[15:8] & rx[7:0]);
    @(posedge sys_clk);
    array_busy <= 1'b0;
    array_done <= 1'b1;
    array_fail <= 1'b1;
    @(posedge sys_clk);
    array_done <= 1'b0;
    array_fail <= 1'b0;
    idle(5);
    rd_status(8'h44);
    host_u.xfer(8, 32'h06000000, rx);
    req(`KIND_PROG, 5'h00, 1'b1);
    idle(3);
    rd_status(8'h06);
    $display("TB: array tests done");
    finish_test();
  end
endmodule // tb_top
